/* File: rtl/adc_link_side.sv */
// serial clock side: clock edge counter and stream exit command detector
`timescale 1ns/1ps
`include "adc_readout_consts.svh"

module adc_link_side #(
	parameter int CNT_W = `RDC_LINK_CNT_W
) (
	input wire logic i_sclk,
	input wire logic i_rst,
	input wire logic i_din,
	output logic [CNT_W-1:0] o_cnt_gray,
	output logic o_exit_tgl
);

	logic rst_meta_q;
	logic rst_sync_q;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] gray_q, gray_d;
	logic [7:0] shift_q, shift_d;
	logic [6:0] ones_q, ones_d;
	logic tgl_q, tgl_d;
	logic hit;

	// ****************************************************************
	// reset brought onto the serial clock; the bench must clock it in reset
	// ****************************************************************
	always_ff @(posedge i_sclk) begin
		rst_meta_q <= i_rst;
		rst_sync_q <= rst_meta_q;
	end

	// ****************************************************************
	// edge count (gray for the crossing) and command watch on the data-in pin
	// ****************************************************************
	always_comb begin
		cnt_d = cnt_q + 1'b1;
		gray_d = cnt_d ^ (cnt_d >> 1);
		shift_d = {shift_q[6:0], i_din};
		ones_d = i_din ? ones_q + 1'b1 : 7'h00;
		// byte boundary exit command, or a run of 64 ones; either one toggles the exit
		hit = (cnt_q[2:0] == 3'h7 && shift_d == `RDC_EXIT_CMD)
			|| (i_din && ones_q == 7'(`RDC_EXIT_ONES - 1));
		if (hit) begin
			ones_d = 7'h00;
		end
		tgl_d = tgl_q ^ hit;
		if (rst_sync_q) begin
			cnt_d = '0;
			gray_d = '0;
			shift_d = 8'h00;
			ones_d = 7'h00;
			tgl_d = 1'b0;
		end
	end

	always_ff @(posedge i_sclk) begin
		cnt_q <= cnt_d;
		gray_q <= gray_d;
		shift_q <= shift_d;
		ones_q <= ones_d;
		tgl_q <= tgl_d;
	end

	assign o_cnt_gray = gray_q;
	assign o_exit_tgl = tgl_q;

endmodule : adc_link_side

/* File: rtl/adc_result_readout_control.sv */
// result readout control: coding, config register, streaming reads over the serial pins
// Behaviour
// - bit 14 picks straight binary over zero to full scale when clear, offset binary when set.
// - a positive full-scale input reads as all ones in either coding.
// - in offset binary, zero input reads mid-scale and negative full scale reads all zeros.
// - bit 13 picks the 1.25 V internal reference when set, 2.5 V when clear, only with ref enable.
// - without chip select the data pin is released 10 ns or 100 ns after the last clock, by bit 12.
// - with bit 11 set the host reads results by clocking after data-ready falls, no command first.
// - in streaming reads data-ready frames the read and clocks before it falls are ignored.
// - a read still open four master clocks before the next result is abandoned, data-ready high.
// - the host leaves streaming with 64 ones or the byte 0x42, accepted without a check byte.
// - streaming reads are off whenever the result fifo is enabled.
// - with bit 10 set each 24-bit result is followed by the 8-bit status in the same read.
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "adc_readout_consts.svh"

module adc_result_readout_control #(
	parameter int CNT_W = `RDC_LINK_CNT_W
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_sclk,
	input wire logic i_din,
	input wire logic i_cs_n,
	input wire logic [`RDC_ADDR_W-1:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	input wire logic [23:0] i_result,
	input wire logic [7:0] i_status,
	input wire logic i_result_valid,
	input wire logic [7:0] i_conv_due_in,
	input wire logic i_fifo_en,
	input wire logic i_crc_en,
	input wire logic i_chip_select_use_en,
	input wire logic i_int_ref_en,
	output logic o_vref_low_sel,
	output logic o_drdy_n,
	output logic o_dout,
	output logic o_dout_oe,
	output logic o_streaming_active
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	adc_readout_pkg::cfg_s cfg_q, cfg_d;
	adc_readout_pkg::frame_s frame_q, frame_d;
	adc_readout_pkg::read_state_e state_q, state_d;
	logic [15:0] rdata_q, rdata_d;
	logic [CNT_W-1:0] cnt_gray;
	logic [CNT_W-1:0] gray_meta_q, gray_sync_q;
	logic [CNT_W-1:0] cnt_bin;
	logic [CNT_W-1:0] base_q, base_d;
	logic [CNT_W-1:0] pos;
	logic exit_tgl;
	logic tgl_meta_q, tgl_sync_q, tgl_old_q;
	logic cs_meta_q, cs_sync_q;
	logic exit_hit;
	logic active;
	logic abandon;
	logic abandoned_q, abandoned_d;
	logic [3:0] del_q, del_d;
	logic drdy_n_q, drdy_n_d;
	logic dout_q, dout_d;
	logic oe_q, oe_d;
	logic vref_q, vref_d;
	logic act_q;
	logic [23:0] coded;
	logic [31:0] body;
	logic [5:0] body_len;
	logic [5:0] idx;
	// a literal cannot be bit-selected, so the reset word is held in a named constant
	localparam logic [15:0] CFG_RESET = `RDC_CFG_RESET;

	// ****************************************************************
	// serial clock side
	// ****************************************************************
	adc_link_side #(
		.CNT_W(CNT_W)
	) u_link (
		.i_sclk(i_sclk),
		.i_rst(i_rst),
		.i_din(i_din),
		.o_cnt_gray(cnt_gray),
		.o_exit_tgl(exit_tgl)
	);

	// ****************************************************************
	// crossings: gray edge count, exit toggle and chip select pin
	// ****************************************************************
	always_ff @(posedge i_clk) begin
		gray_meta_q <= cnt_gray;
		gray_sync_q <= gray_meta_q;
		tgl_meta_q <= exit_tgl;
		tgl_sync_q <= tgl_meta_q;
		tgl_old_q <= tgl_sync_q;
		cs_meta_q <= i_cs_n;
		cs_sync_q <= cs_meta_q;
	end

	// gray to binary, then the bit position within the open frame
	always_comb begin
		cnt_bin[CNT_W-1] = gray_sync_q[CNT_W-1];
		for (int i = CNT_W - 2; i >= 0; i--) begin
			cnt_bin[i] = cnt_bin[i+1] ^ gray_sync_q[i];
		end
	end
	assign pos = cnt_bin - base_q;
	assign exit_hit = tgl_sync_q ^ tgl_old_q;

	// ****************************************************************
	// result coding and frame assembly
	// ****************************************************************
	always_comb begin
		if (cfg_q.offset_binary_en) begin
			coded = {~i_result[23], i_result[22:0]};
		end else if (i_result[23]) begin
			coded = 24'h00_0000;
		end else begin
			// doubling keeps full scale at all ones on half the signed span
			coded = {i_result[22:0], i_result[22]};
		end
		if (cfg_q.status_append_en) begin
			body = {coded, i_status};
			body_len = 6'(`RDC_DATA_BITS + `RDC_STATUS_BITS);
		end else begin
			body = {coded, 8'h00};
			body_len = 6'(`RDC_DATA_BITS);
		end
	end

	// ****************************************************************
	// config register, status readback and hardware exit of streaming
	// ****************************************************************
	always_comb begin
		cfg_d = cfg_q;
		rdata_d = 16'h0000;
		if (exit_hit) begin
			cfg_d.streaming_result_read_en = 1'b0;
		end
		if (i_wr && i_addr == `RDC_CFG_ADDR) begin
			cfg_d.offset_binary_en = i_wdata[`RDC_BIT_OFFSET_BIN];
			cfg_d.internal_vref_level_sel = i_wdata[`RDC_BIT_VREF_SEL];
			cfg_d.dataout_release_delay_sel = i_wdata[`RDC_BIT_DOUT_DEL];
			cfg_d.streaming_result_read_en = i_wdata[`RDC_BIT_STREAM_EN];
			cfg_d.status_append_en = i_wdata[`RDC_BIT_STATUS_APP];
		end
		if (i_rd && i_addr == `RDC_CFG_ADDR) begin
			rdata_d[`RDC_BIT_OFFSET_BIN] = cfg_q.offset_binary_en;
			rdata_d[`RDC_BIT_VREF_SEL] = cfg_q.internal_vref_level_sel;
			rdata_d[`RDC_BIT_DOUT_DEL] = cfg_q.dataout_release_delay_sel;
			rdata_d[`RDC_BIT_STREAM_EN] = cfg_q.streaming_result_read_en;
			rdata_d[`RDC_BIT_STATUS_APP] = cfg_q.status_append_en;
		end else if (i_rd && i_addr == `RDC_STAT_ADDR) begin
			rdata_d[4:0] = {abandoned_q, state_q, act_q, drdy_n_q};
		end
		vref_d = cfg_q.internal_vref_level_sel & i_int_ref_en;
		if (i_rst) begin
			cfg_d = adc_readout_pkg::cfg_s'({
				CFG_RESET[`RDC_BIT_OFFSET_BIN],
				CFG_RESET[`RDC_BIT_VREF_SEL],
				CFG_RESET[`RDC_BIT_DOUT_DEL],
				CFG_RESET[`RDC_BIT_STREAM_EN],
				CFG_RESET[`RDC_BIT_STATUS_APP]});
			rdata_d = 16'h0000;
			vref_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		cfg_q <= cfg_d;
		rdata_q <= rdata_d;
		vref_q <= vref_d;
	end

	// ****************************************************************
	// streaming read sequencer
	// ****************************************************************
	assign active = cfg_q.streaming_result_read_en & ~i_fifo_en;
	assign abandon = state_q == adc_readout_pkg::ST_READY
		&& i_conv_due_in == 8'(`RDC_ABANDON_LEAD);
	assign idx = 6'(`RDC_FRAME_W - 1) - pos[5:0];

	always_comb begin
		state_d = state_q;
		frame_d = frame_q;
		base_d = base_q;
		del_d = del_q;
		abandoned_d = abandoned_q;
		dout_d = dout_q;
		oe_d = oe_q;
		unique case (state_q)
			adc_readout_pkg::ST_IDLE: begin
				oe_d = 1'b0;
			end
			adc_readout_pkg::ST_READY: begin
				oe_d = ~(i_chip_select_use_en & cs_sync_q);
				if (pos[5:0] < frame_q.len && pos < CNT_W'(`RDC_FRAME_W)) begin
					dout_d = frame_q.bits[idx];
				end else begin
					// whole frame clocked out: the result is spent
					state_d = adc_readout_pkg::ST_TAIL;
					del_d = cfg_q.dataout_release_delay_sel
						? 4'(`RDC_DEL_LONG_CYC - 1) : 4'(`RDC_DEL_SHORT_CYC - 1);
				end
				if (abandon) begin
					state_d = adc_readout_pkg::ST_IDLE;
					oe_d = 1'b0;
					abandoned_d = 1'b1;
				end
			end
			adc_readout_pkg::ST_TAIL: begin
				del_d = del_q - 4'h1;
				if (i_chip_select_use_en ? cs_sync_q : del_q == 4'h0) begin
					state_d = adc_readout_pkg::ST_IDLE;
					oe_d = 1'b0;
				end
			end
			default: begin
				state_d = adc_readout_pkg::ST_IDLE;
				oe_d = 1'b0;
			end
		endcase
		// a new result opens a fresh frame; the edge base drops any old bits
		if (i_result_valid && active) begin
			state_d = adc_readout_pkg::ST_READY;
			frame_d.bits = {body, (i_crc_en ? adc_readout_pkg::crc8(body, body_len) : 8'h00)};
			frame_d.len = body_len + (i_crc_en ? 6'(`RDC_CRC_BITS) : 6'h00);
			base_d = cnt_bin;
			dout_d = frame_d.bits[`RDC_FRAME_W-1];
			oe_d = ~(i_chip_select_use_en & cs_sync_q);
		end
		if (!active) begin
			state_d = adc_readout_pkg::ST_IDLE;
			oe_d = 1'b0;
		end
		if (i_rd && i_addr == `RDC_STAT_ADDR && !(abandon && state_d == adc_readout_pkg::ST_IDLE)) begin
			abandoned_d = 1'b0;
		end
		drdy_n_d = state_d != adc_readout_pkg::ST_READY;
		if (i_rst) begin
			state_d = adc_readout_pkg::ST_IDLE;
			frame_d = '0;
			base_d = '0;
			del_d = 4'h0;
			abandoned_d = 1'b0;
			dout_d = 1'b0;
			oe_d = 1'b0;
			drdy_n_d = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		state_q <= state_d;
		frame_q <= frame_d;
		base_q <= base_d;
		del_q <= del_d;
		abandoned_q <= abandoned_d;
		dout_q <= dout_d;
		oe_q <= oe_d;
		drdy_n_q <= drdy_n_d;
		act_q <= i_rst ? 1'b0 : active;
	end

	assign o_rdata = rdata_q;
	assign o_vref_low_sel = vref_q;
	assign o_drdy_n = drdy_n_q;
	assign o_dout = dout_q;
	assign o_dout_oe = oe_q;
	assign o_streaming_active = act_q;

	// ****************************************************************
	// assertions
	// ****************************************************************
	property p_unipolar_negative;
		@(posedge i_clk) disable iff (i_rst)
		(i_result_valid && active && !cfg_q.offset_binary_en && i_result[23])
			|=> frame_q.bits[39:16] == 24'h00_0000;
	endproperty
	a_unipolar_negative: assert property (p_unipolar_negative) else $error("unipolar clip");

	property p_full_scale;
		@(posedge i_clk) disable iff (i_rst)
		(i_result_valid && active && i_result == 24'h7F_FFFF)
			|=> frame_q.bits[39:16] == 24'hFF_FFFF;
	endproperty
	a_full_scale: assert property (p_full_scale) else $error("full scale not all ones");

	property p_mid_scale;
		@(posedge i_clk) disable iff (i_rst)
		(i_result_valid && active && cfg_q.offset_binary_en && i_result == 24'h00_0000)
			|=> frame_q.bits[39:16] == 24'h80_0000;
	endproperty
	a_mid_scale: assert property (p_mid_scale) else $error("zero not mid scale");

	property p_vref_sel;
		@(posedge i_clk) disable iff (i_rst)
		##1 o_vref_low_sel == $past(cfg_q.internal_vref_level_sel && i_int_ref_en);
	endproperty
	a_vref_sel: assert property (p_vref_sel) else $error("vref select wrong");

	property p_long_release;
		@(posedge i_clk) disable iff (i_rst)
		($rose(state_q == adc_readout_pkg::ST_TAIL) && cfg_q.dataout_release_delay_sel
			&& !i_chip_select_use_en && active && !i_result_valid && $stable(cfg_q))
			|-> ##9 o_dout_oe ##1 !o_dout_oe;
	endproperty
	a_long_release: assert property (p_long_release) else $error("release delay wrong");

	property p_abandon;
		@(posedge i_clk) disable iff (i_rst)
		(abandon && !i_result_valid) |=> o_drdy_n && !o_dout_oe && abandoned_q;
	endproperty
	a_abandon: assert property (p_abandon) else $error("read not abandoned");

	property p_fifo_blocks;
		@(posedge i_clk) disable iff (i_rst)
		i_fifo_en |=> o_drdy_n && state_q == adc_readout_pkg::ST_IDLE;
	endproperty
	a_fifo_blocks: assert property (p_fifo_blocks) else $error("stream under fifo");

	property p_frame_len;
		@(posedge i_clk) disable iff (i_rst)
		(i_result_valid && active)
			|=> frame_q.len == 6'(24 + ($past(cfg_q.status_append_en) ? 8 : 0)
				+ ($past(i_crc_en) ? 8 : 0)) && base_q == $past(cnt_bin);
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

	property p_exit;
		@(posedge i_clk) disable iff (i_rst)
		(exit_hit && !i_wr) |=> !cfg_q.streaming_result_read_en ##1 !o_streaming_active;
	endproperty
	a_exit: assert property (p_exit) else $error("stream exit missed");

endmodule : adc_result_readout_control

/* File: shared/adc_readout_consts.svh */
// constants for the result readout block: offsets, fields, resets, timing
`ifndef ADC_READOUT_CONSTS_SVH
`define ADC_READOUT_CONSTS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define RDC_ADDR_W 4
`define RDC_CFG_ADDR 4'h0
`define RDC_STAT_ADDR 4'h1
`define RDC_CFG_RESET 16'h4000
`define RDC_BIT_OFFSET_BIN 14
`define RDC_BIT_VREF_SEL 13
`define RDC_BIT_DOUT_DEL 12
`define RDC_BIT_STREAM_EN 11
`define RDC_BIT_STATUS_APP 10

// ****************************************************************
// frame layout
// ****************************************************************
`define RDC_DATA_BITS 24
`define RDC_STATUS_BITS 8
`define RDC_CRC_BITS 8
`define RDC_FRAME_W 40
`define RDC_CRC_POLY 8'h07
`define RDC_EXIT_CMD 8'h42
`define RDC_EXIT_ONES 64
`define RDC_LINK_CNT_W 8

// ****************************************************************
// timing
// ****************************************************************
`define RDC_CLK_PERIOD_NS 10
`define RDC_DEL_SHORT_NS 10
`define RDC_DEL_LONG_NS 100
`define RDC_DEL_SHORT_CYC ((`RDC_DEL_SHORT_NS + `RDC_CLK_PERIOD_NS - 1) / `RDC_CLK_PERIOD_NS)
`define RDC_DEL_LONG_CYC ((`RDC_DEL_LONG_NS + `RDC_CLK_PERIOD_NS - 1) / `RDC_CLK_PERIOD_NS)
`define RDC_ABANDON_LEAD 4

`endif

/* File: shared/adc_readout_pkg.sv */
// types and the frame check function for the result readout block
`include "adc_readout_consts.svh"

package adc_readout_pkg;

	// ****************************************************************
	// states and carriers
	// ****************************************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READY = 2'b01,
		ST_TAIL = 2'b10
	} read_state_e;

	typedef struct packed {
		logic offset_binary_en;
		logic internal_vref_level_sel;
		logic dataout_release_delay_sel;
		logic streaming_result_read_en;
		logic status_append_en;
	} cfg_s;

	typedef struct packed {
		logic [`RDC_FRAME_W-1:0] bits;
		logic [5:0] len;
	} frame_s;

	// crc-8 over the first n bits of d, msb first
	function automatic logic [7:0] crc8(input logic [31:0] d, input logic [5:0] n);
		logic [7:0] c;
		logic fb;
		c = 8'h00;
		for (int i = 0; i < 32; i++) begin
			if (6'(i) < n) begin
				fb = c[7] ^ d[31-i];
				c = {c[6:0], 1'b0} ^ (fb ? `RDC_CRC_POLY : 8'h00);
			end
		end
		return c;
	endfunction : crc8

endpackage : adc_readout_pkg

/* File: tb/adc_result_readout_control_tb.sv */
// self-checking bench for the result readout block
`timescale 1ns/1ps
`include "adc_readout_consts.svh"

module adc_result_readout_control_tb;
	// ****************************************************************
	// signals and instances
	// ****************************************************************
	logic i_clk, i_rst, i_sclk, i_din, i_cs_n, i_wr, i_rd, i_result_valid;
	logic [`RDC_ADDR_W-1:0] i_addr;
	logic [15:0] i_wdata, o_rdata, rd;
	logic [23:0] i_result;
	logic [7:0] i_status, i_conv_due_in;
	logic i_fifo_en, i_crc_en, i_chip_select_use_en, i_int_ref_en;
	logic o_vref_low_sel, o_drdy_n, o_dout, o_dout_oe, o_streaming_active;
	logic [63:0] rx, hold;
	int fail_count = 0;
	int checked = 0;
	int c_short, c_long;
	logic [23:0] raw_t [4] = '{24'h7f_ffff, 24'h80_0000, 24'h00_0001, 24'h00_0000};
	logic [23:0] uni_t [4] = '{24'hff_ffff, 24'h00_0000, 24'h00_0002, 24'h00_0000};
	logic [23:0] off_t [4] = '{24'hff_ffff, 24'h00_0000, 24'h80_0001, 24'h80_0000};

	adc_result_readout_control adc_result_readout_control_i (.i_clk, .i_rst, .i_sclk, .i_din,
		.i_cs_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_result, .i_status,
		.i_result_valid, .i_conv_due_in, .i_fifo_en, .i_crc_en, .i_chip_select_use_en,
		.i_int_ref_en, .o_vref_low_sel, .o_drdy_n, .o_dout, .o_dout_oe, .o_streaming_active);
	// a released data pin reads high through its pull-up
	host_serial_model host_serial_model_i (.i_dout(o_dout_oe ? o_dout : 1'b1), .i_drdy_n(o_drdy_n),
		.o_sclk(i_sclk), .o_din(i_din));

	// 100 MHz system clock
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : reg_wr

	// read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : reg_rd

	task automatic set_cfg(input logic [15:0] d);
		reg_wr(`RDC_CFG_ADDR, d);
		repeat (2) @(posedge i_clk);
		#1;
	endtask : set_cfg

	// cycles from data-ready rising at the end of a frame until the data pin is let go
	task automatic gap(output int c);
		c = 0;
		@(posedge o_drdy_n);
		while (o_dout_oe !== 1'b0 && c < 40) begin
			@(posedge i_clk);
			#1;
			c++;
		end
	endtask : gap

	task automatic pulse_result(input logic [23:0] raw, input logic [7:0] st);
		@(posedge i_clk);
		i_result <= raw;
		i_status <= st;
		i_result_valid <= 1'b1;
		@(posedge i_clk);
		i_result_valid <= 1'b0;
		@(posedge i_clk);
		#1;
	endtask : pulse_result

	task automatic stream(input logic [23:0] raw, input logic [7:0] st, input int n);
		pulse_result(raw, st);
		check(o_drdy_n, 1'b0);
		check(o_dout_oe, 1'b1);
		host_serial_model_i.read(n, rx);
	endtask : stream

	// counts cycles until the data pin is let go; a frame must be closed by then
	task automatic settle(output int c);
		c = 0;
		while (o_dout_oe !== 1'b0 && c < 40) begin
			@(posedge i_clk);
			#1;
			c++;
		end
		check(o_drdy_n, 1'b1);
	endtask : settle

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		i_rst = 1'b1;
		i_addr = '0;
		i_wdata = '0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_result = '0;
		i_status = '0;
		i_result_valid = 1'b0;
		i_conv_due_in = 8'hff;
		i_fifo_en = 1'b0;
		i_crc_en = 1'b0;
		i_chip_select_use_en = 1'b0;
		i_cs_n = 1'b1;
		i_int_ref_en = 1'b0;
		// reset must also span serial edges, so it lasts longer than ten cycles
		fork
			host_serial_model_i.shift(4, 64'h0000_0000_0000_0000, hold);
			repeat (50) @(posedge i_clk);
		join
		@(posedge i_clk);
		i_rst <= 1'b0;
		// the link side stays in reset for two more serial edges; spend them here
		host_serial_model_i.shift(2, 64'h0000_0000_0000_0000, hold);
		@(posedge i_clk);
		#1;
		check({o_drdy_n, o_dout_oe, o_streaming_active, o_vref_low_sel}, 4'h8);
		reg_rd(`RDC_CFG_ADDR, rd);
		check(rd, `RDC_CFG_RESET);
		reg_wr(4'h7, 16'hffff);
		reg_rd(4'h7, rd);
		check(rd, 16'h0000);
		reg_rd(`RDC_CFG_ADDR, rd);
		check(rd, `RDC_CFG_RESET);
		$display("test reset_and_map done");

		// both codings over the boundary inputs
		for (int m = 0; m < 2; m++) begin
			set_cfg(m ? 16'h4800 : 16'h0800);
			check(o_streaming_active, 1'b1);
			for (int i = 0; i < 4; i++) begin
				stream(raw_t[i], 8'h00, 24);
				settle(c_short);
				check(rx[23:0], m ? off_t[i] : uni_t[i]);
			end
		end
		$display("test coding done");

		// frame closes on the 24th edge and not before
		stream(24'h00_0000, 8'h00, 23);
		hold = rx;
		check(o_drdy_n, 1'b0);
		fork
			host_serial_model_i.shift(1, 64'h0000_0000_0000_0000, rx);
			gap(c_short);
		join
		check(c_short, `RDC_DEL_SHORT_CYC);
		settle(c_short);
		check({hold[22:0], rx[0]}, 24'h80_0000);
		set_cfg(16'h5800);
		fork
			stream(24'h00_0000, 8'h00, 24);
			gap(c_long);
		join
		check(c_long, `RDC_DEL_LONG_CYC);
		settle(c_long);
		$display("test length_and_release done");

		// status appended, and stray clocks before a frame are ignored
		set_cfg(16'h4c00);
		stream(24'h00_0010, 8'ha5, 32);
		settle(c_short);
		check(rx[31:0], {24'h80_0010, 8'ha5});
		host_serial_model_i.shift(8, 64'h0000_0000_0000_0000, rx);
		check(o_drdy_n, 1'b1);
		stream(24'h12_3456, 8'h3c, 32);
		settle(c_short);
		check(rx[31:0], {24'h92_3456, 8'h3c});
		$display("test status_and_framing done");

		// read cut short by the next conversion, then a clean frame
		stream(24'h00_0abc, 8'h11, 8);
		@(posedge i_clk);
		i_conv_due_in <= 8'h04;
		@(posedge i_clk);
		i_conv_due_in <= 8'hff;
		@(posedge i_clk);
		#1;
		check({o_drdy_n, o_dout_oe}, 2'b10);
		reg_rd(`RDC_STAT_ADDR, rd);
		check(rd[4], 1'b1);
		reg_rd(`RDC_STAT_ADDR, rd);
		check(rd[4], 1'b0);
		stream(24'h7f_fff0, 8'h22, 32);
		settle(c_short);
		check(rx[31:0], {24'hff_fff0, 8'h22});
		$display("test abandon done");

		// fifo use shuts streaming off
		@(posedge i_clk);
		i_fifo_en <= 1'b1;
		repeat (3) @(posedge i_clk);
		#1;
		check(o_streaming_active, 1'b0);
		pulse_result(24'h00_0001, 8'h00);
		check(o_drdy_n, 1'b1);
		@(posedge i_clk);
		i_fifo_en <= 1'b0;
		repeat (3) @(posedge i_clk);
		#1;
		check(o_streaming_active, 1'b1);
		$display("test fifo done");

		// low reference only with the internal reference on
		set_cfg(16'h6c00);
		check(o_vref_low_sel, 1'b0);
		@(posedge i_clk);
		i_int_ref_en <= 1'b1;
		repeat (3) @(posedge i_clk);
		#1;
		check(o_vref_low_sel, 1'b1);
		set_cfg(16'h4c00);
		check(o_vref_low_sel, 1'b0);
		$display("test vref done");

		// check bytes on: a whole frame checks out, a cut one reads as ones and fails
		@(posedge i_clk);
		i_crc_en <= 1'b1;
		stream(24'h00_0001, 8'h5a, 40);
		settle(c_short);
		check(rx[39:8], {24'h80_0001, 8'h5a});
		check(host_serial_model_i.crc_good(rx[39:0]), 1'b1);
		pulse_result(24'h00_0002, 8'h00);
		@(posedge i_clk);
		i_conv_due_in <= 8'h04;
		@(posedge i_clk);
		i_conv_due_in <= 8'hff;
		host_serial_model_i.read(40, rx);
		check(o_drdy_n, 1'b1);
		check(host_serial_model_i.crc_good(rx[39:0]), 1'b0);
		$display("test check_byte done");

		// both ways out of streaming, with check bytes on
		host_serial_model_i.shift(8, 64'h0000_0000_0000_0042, rx);
		repeat (10) @(posedge i_clk);
		reg_rd(`RDC_CFG_ADDR, rd);
		check(rd, 16'h4400);
		set_cfg(16'h4c00);
		host_serial_model_i.shift(64, 64'hffff_ffff_ffff_ffff, rx);
		repeat (10) @(posedge i_clk);
		reg_rd(`RDC_CFG_ADDR, rd);
		check(rd, 16'h4400);
		check(o_streaming_active, 1'b0);
		$display("test exit done");
		tally_and_finish();
	end

	// watchdog well beyond the expected run of about 90 us
	initial begin
		#400_000;
		fail_count++;
		$display("ERROR at %0t: watchdog expired", $time);
		tally_and_finish();
	end

endmodule : adc_result_readout_control_tb

/* File: tb/host_serial_model.sv */
// host side serial master: frames the serial clock and shifts bits both ways
`timescale 1ns/1ps
`include "adc_readout_consts.svh"

module host_serial_model (
	input wire logic i_dout,
	input wire logic i_drdy_n,
	output logic o_sclk,
	output logic o_din
);
	// ****************************************************************
	// serial clock and data
	// ****************************************************************
	localparam int HALF_NS = 80;

	// clock rests low outside frames, data line idles high
	initial begin
		o_sclk = 1'b0;
		o_din = 1'b1;
	end

	// data changes while the clock is low and is captured at each rising edge;
	// the small lead keeps serial edges off the system clock edges
	task automatic shift(input int n, input logic [63:0] tx, output logic [63:0] rx);
		rx = '0;
		#3;
		for (int i = 0; i < n; i++) begin
			o_din = tx[n-1-i];
			#HALF_NS o_sclk = 1'b1;
			rx = {rx[62:0], i_dout};
			#HALF_NS o_sclk = 1'b0;
		end
		o_din = 1'b1;
	endtask : shift

	// a read needs no command first: wait one serial period from the call, then clock; data-ready is not watched
	task automatic read(input int n, output logic [63:0] rx);
		#(2 * HALF_NS);
		shift(n, 64'h0000_0000_0000_0000, rx);
	endtask : read

	// host side frame check: true when the check byte agrees with the crc of the 32 bits before it
	function automatic logic crc_good(input logic [39:0] f);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 39; i >= 8; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ f[i]) ? `RDC_CRC_POLY : 8'h00);
		end
		return c == f[7:0];
	endfunction : crc_good

endmodule : host_serial_model
